// File: shared/sip_pkg.sv
// constants, state codes and byte kinds for the two-wire register target port
package sip_pkg;

	localparam int          BYTE_W    = 8;       // bits per byte on the link
	localparam logic [3:0]  BYTE_BITS = 4'h8;    // data bits before the acknowledge slot
	localparam logic [5:0]  ADDR_HI   = 6'h34;   // fixed upper six address bits, 110100
	localparam logic [7:0]  IDX_RST   = 8'h00;   // register index after reset
	localparam logic [7:0]  SHIFT_RST = 8'h00;   // shift register after reset
	localparam logic [3:0]  CNT_RST   = 4'h0;    // bit counter after reset

	// one-hot states of the target engine
	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_RX    = 8'h02,
		ST_RXACK = 8'h04,
		ST_WAIT  = 8'h08,
		ST_TX    = 8'h10,
		ST_TXACK = 8'h20,
		ST_TXNXT = 8'h40,
		ST_IGN   = 8'h80
	} sip_state_e;

	// what the byte being received means
	typedef enum logic [2:0] {
		K_ADDR = 3'h1,
		K_IDX  = 3'h2,
		K_DATA = 3'h4
	} sip_kind_e;

endpackage

// File: shared/sip_evt_if.sv
// line levels and bus events passed from the line detector to the target engine
`timescale 1ns/100ps
interface sip_evt_if;
	logic scl_lvl;    // synchronised clock line
	logic sda_lvl;    // synchronised data line
	logic ad0_lvl;    // synchronised address-select pin
	logic scl_rise;   // clock line rose
	logic scl_fall;   // clock line fell
	logic start;      // START or repeated START seen
	logic stop;       // STOP seen

	modport det (output scl_lvl, sda_lvl, ad0_lvl, scl_rise, scl_fall, start, stop);
	modport eng (input  scl_lvl, sda_lvl, ad0_lvl, scl_rise, scl_fall, start, stop);
endinterface

// File: logic/sip_line_detect.sv
// pin synchronisers and START/STOP/edge detection for the two-wire link
`timescale 1ns/100ps
module sip_line_detect (
	input  wire logic mclk_in,   // system clock
	input  wire logic arst_n_in, // async reset, active low
	input  wire logic scl_in,    // clock pin level
	input  wire logic sda_in,    // data pin level
	input  wire logic ad0_in,    // address-select pin level
	sip_evt_if.det    ev         // events toward the engine
);
	logic [2:0] meta_r;  // first synchroniser stage, read only by sync_r
	logic [2:0] sync_r;  // second stage: {ad0, sda, scl}
	logic [1:0] prev_r;  // one more stage for edge finding: {sda, scl}

	// -------------------------------------------------------------
	// synchronisers
	// -------------------------------------------------------------
	// two flops before any logic; the third stage only gives edges
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			meta_r <= 3'h7;
			sync_r <= 3'h7;
			prev_r <= 2'h3;
		end
		else
		begin
			meta_r <= {ad0_in, sda_in, scl_in};
			sync_r <= meta_r;
			prev_r <= sync_r[1:0];
		end
	end

	// -------------------------------------------------------------
	// events
	// -------------------------------------------------------------
	// a data edge with the clock high on both samples is a condition
	assign ev.scl_lvl  = sync_r[0];
	assign ev.sda_lvl  = sync_r[1];
	assign ev.ad0_lvl  = sync_r[2];
	assign ev.scl_rise = sync_r[0] & ~prev_r[0];
	assign ev.scl_fall = ~sync_r[0] & prev_r[0];
	assign ev.start    = sync_r[0] & prev_r[0] & prev_r[1] & ~sync_r[1];
	assign ev.stop     = sync_r[0] & prev_r[0] & ~prev_r[1] & sync_r[1];

endmodule // sip_line_detect

// File: logic/sip_target_port.sv
// two-wire target port giving a host read and write access to the register space
`timescale 1ns/100ps
module sip_target_port (
	input  wire logic       mclk_in,                 // system clock, 200 MHz
	input  wire logic       arst_n_in,               // async reset, active low
	input  wire logic       scl_in,                  // clock pin input
	output logic            scl_out,                 // clock pin output value (always low)
	output logic            scl_oe_out,              // clock pin drive: stretch
	input  wire logic       sda_in,                  // data pin input
	output logic            sda_out,                 // data pin output value (always low)
	output logic            sda_oe_out,              // data pin drive: pull low
	input  wire logic       addr_select_pin_in,      // address-select pin input
	output logic            addr_select_pin_out,     // address-select pin value in SPI use
	output logic            addr_select_pin_oe_out,  // address-select pin drive in SPI use
	input  wire logic       twowire_port_disable_in, // keeps the pins in SPI use
	input  wire logic       spi_sdo_in,              // SPI serial output from SPI logic
	input  wire logic       spi_sdo_oe_in,           // SPI output enable from SPI logic
	output logic            spi_sclk_out,            // synchronised clock pin for SPI logic
	output logic            spi_sdi_out,             // synchronised data pin for SPI logic
	output logic            busy_out,                // bus busy, START to STOP
	output logic [7:0]      register_index_out,      // register being written or read
	output logic            wr_en_out,               // one-cycle write strobe
	output logic [7:0]      wr_data_out,             // byte to store
	output logic            rd_req_out,              // one-cycle read request
	input  wire logic       rd_ready_in,             // read data valid
	input  wire logic [7:0] rd_data_in               // read data
);
	sip_evt_if ev ();

	sip_pkg::sip_state_e state_r, state_nxt;
	sip_pkg::sip_kind_e  kind_r,  kind_nxt;
	logic       rw_r,      rw_nxt;
	logic [3:0] cnt_r,     cnt_nxt;
	logic [7:0] shift_r,   shift_nxt;
	logic [7:0] idx_r,     idx_nxt;
	logic       sda_oe_r,  sda_oe_nxt;
	logic       scl_oe_r,  scl_oe_nxt;
	logic       busy_r,    busy_nxt;
	logic       wr_en_r,   wr_en_nxt;
	logic [7:0] wr_data_r, wr_data_nxt;
	logic       rd_req_r,  rd_req_nxt;
	logic       ad0_r;
	logic       ad0_oe_r;

	// -------------------------------------------------------------
	// line detector
	// -------------------------------------------------------------
	sip_line_detect u_det (
		.mclk_in   (mclk_in),
		.arst_n_in (arst_n_in),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.ad0_in    (addr_select_pin_in),
		.ev        (ev.det)
	);

	// -------------------------------------------------------------
	// decodes
	// -------------------------------------------------------------
	// the port is off while SPI owns the shared pins
	wire       link_on   = !twowire_port_disable_in;
	wire       byte_done = ev.scl_fall && (cnt_r == sip_pkg::BYTE_BITS);
	wire [6:0] own_addr  = {sip_pkg::ADDR_HI, ev.ad0_lvl};
	wire       addr_hit  = (shift_r[7:1] == own_addr);
	wire       host_ack  = !ev.sda_lvl;
	// read data taken only after the request pulse has gone out
	wire       rd_take   = (state_r == sip_pkg::ST_WAIT) && !rd_req_r && rd_ready_in;
	wire [3:0] cnt_inc   = cnt_r + 4'h1;
	wire [7:0] idx_inc   = idx_r + 8'h01;

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	// START and STOP win over any byte activity; a repeated START
	// simply restarts address reception with the bus still busy
	always_comb
	begin
		state_nxt   = state_r;
		kind_nxt    = kind_r;
		rw_nxt      = rw_r;
		cnt_nxt     = cnt_r;
		shift_nxt   = shift_r;
		idx_nxt     = idx_r;
		sda_oe_nxt  = sda_oe_r;
		scl_oe_nxt  = scl_oe_r;
		busy_nxt    = busy_r;
		wr_en_nxt   = 1'b0;
		wr_data_nxt = wr_data_r;
		rd_req_nxt  = 1'b0;
		if (!link_on)
		begin
			state_nxt  = sip_pkg::ST_IDLE;
			busy_nxt   = 1'b0;
			sda_oe_nxt = 1'b0;
			scl_oe_nxt = 1'b0;
		end
		else if (ev.start)
		begin
			state_nxt  = sip_pkg::ST_RX;
			kind_nxt   = sip_pkg::K_ADDR;
			cnt_nxt    = sip_pkg::CNT_RST;
			busy_nxt   = 1'b1;
			sda_oe_nxt = 1'b0;
			scl_oe_nxt = 1'b0;
		end
		else if (ev.stop)
		begin
			state_nxt  = sip_pkg::ST_IDLE;
			busy_nxt   = 1'b0;
			sda_oe_nxt = 1'b0;
			scl_oe_nxt = 1'b0;
		end
		else
		begin
			case (state_r)
				sip_pkg::ST_RX:
				begin
					if (ev.scl_rise)
					begin
						shift_nxt = {shift_r[6:0], ev.sda_lvl};
						cnt_nxt   = cnt_inc;
					end
					else if (byte_done)
					begin
						state_nxt  = sip_pkg::ST_RXACK;
						sda_oe_nxt = 1'b1;
						case (kind_r)
							sip_pkg::K_ADDR:
							begin
								rw_nxt = shift_r[0];
								if (!addr_hit)
								begin
									state_nxt  = sip_pkg::ST_IGN;
									sda_oe_nxt = 1'b0;
								end
							end
							sip_pkg::K_IDX:
							begin
								idx_nxt = shift_r;
							end
							default:
							begin
								wr_en_nxt   = 1'b1;
								wr_data_nxt = shift_r;
							end
						endcase
					end
				end
				sip_pkg::ST_RXACK:
				begin
					// acknowledge held for the whole high phase, dropped on the fall
					if (ev.scl_fall)
					begin
						sda_oe_nxt = 1'b0;
						cnt_nxt    = sip_pkg::CNT_RST;
						state_nxt  = sip_pkg::ST_RX;
						if (kind_r == sip_pkg::K_ADDR && rw_r)
						begin
							state_nxt  = sip_pkg::ST_WAIT;
							scl_oe_nxt = 1'b1;
							rd_req_nxt = 1'b1;
						end
						else if (kind_r == sip_pkg::K_ADDR)
						begin
							kind_nxt = sip_pkg::K_IDX;
						end
						else if (kind_r == sip_pkg::K_IDX)
						begin
							kind_nxt = sip_pkg::K_DATA;
						end
						else
						begin
							idx_nxt = idx_inc;
						end
					end
				end
				sip_pkg::ST_WAIT:
				begin
					// clock held low until the register byte is here
					if (rd_take)
					begin
						shift_nxt  = rd_data_in;
						sda_oe_nxt = !rd_data_in[7];
						cnt_nxt    = sip_pkg::CNT_RST;
						state_nxt  = sip_pkg::ST_TX;
					end
				end
				sip_pkg::ST_TX:
				begin
					scl_oe_nxt = 1'b0; // clock freed a cycle after the first bit is set up
					if (ev.scl_rise)
					begin
						cnt_nxt = cnt_inc;
					end
					else if (byte_done)
					begin
						sda_oe_nxt = 1'b0;
						state_nxt  = sip_pkg::ST_TXACK;
					end
					else if (ev.scl_fall)
					begin
						shift_nxt  = {shift_r[6:0], 1'b0};
						sda_oe_nxt = !shift_r[6];
					end
				end
				sip_pkg::ST_TXACK:
				begin
					if (ev.scl_rise)
					begin
						state_nxt = host_ack ? sip_pkg::ST_TXNXT : sip_pkg::ST_IGN;
					end
				end
				sip_pkg::ST_TXNXT:
				begin
					if (ev.scl_fall)
					begin
						idx_nxt    = idx_inc;
						state_nxt  = sip_pkg::ST_WAIT;
						scl_oe_nxt = 1'b1;
						rd_req_nxt = 1'b1;
					end
				end
				sip_pkg::ST_IDLE, sip_pkg::ST_IGN:
				begin
					sda_oe_nxt = 1'b0;
				end
				default:
				begin
					state_nxt  = sip_pkg::ST_IDLE;
					sda_oe_nxt = 1'b0;
					scl_oe_nxt = 1'b0;
				end
			endcase
		end
	end

	// -------------------------------------------------------------
	// state registers
	// -------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_r   <= sip_pkg::ST_IDLE;
			kind_r    <= sip_pkg::K_ADDR;
			rw_r      <= 1'b0;
			cnt_r     <= sip_pkg::CNT_RST;
			shift_r   <= sip_pkg::SHIFT_RST;
			idx_r     <= sip_pkg::IDX_RST;
			sda_oe_r  <= 1'b0;
			scl_oe_r  <= 1'b0;
			busy_r    <= 1'b0;
			wr_en_r   <= 1'b0;
			wr_data_r <= sip_pkg::SHIFT_RST;
			rd_req_r  <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			kind_r    <= kind_nxt;
			rw_r      <= rw_nxt;
			cnt_r     <= cnt_nxt;
			shift_r   <= shift_nxt;
			idx_r     <= idx_nxt;
			sda_oe_r  <= sda_oe_nxt;
			scl_oe_r  <= scl_oe_nxt;
			busy_r    <= busy_nxt;
			wr_en_r   <= wr_en_nxt;
			wr_data_r <= wr_data_nxt;
			rd_req_r  <= rd_req_nxt;
		end
	end

	// -------------------------------------------------------------
	// SPI sharing of the pins
	// -------------------------------------------------------------
	// address-select pin turns into the SPI output only while disabled
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ad0_r    <= 1'b0;
			ad0_oe_r <= 1'b0;
		end
		else
		begin
			ad0_r    <= spi_sdo_in;
			ad0_oe_r <= twowire_port_disable_in & spi_sdo_oe_in;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	// open-drain clock and data pins: the value is always low, only the enable moves
	assign scl_out                = 1'b0;
	assign sda_out                = 1'b0;
	assign scl_oe_out             = scl_oe_r;
	assign sda_oe_out             = sda_oe_r;
	assign addr_select_pin_out    = ad0_r;
	assign addr_select_pin_oe_out = ad0_oe_r;
	assign spi_sclk_out           = ev.scl_lvl;
	assign spi_sdi_out            = ev.sda_lvl;
	assign busy_out               = busy_r;
	assign register_index_out     = idx_r;
	assign wr_en_out              = wr_en_r;
	assign wr_data_out            = wr_data_r;
	assign rd_req_out             = rd_req_r;

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_addr_byte_done;
		link_on && !ev.start && !ev.stop && state_r == sip_pkg::ST_RX
			&& kind_r == sip_pkg::K_ADDR && byte_done;
	endsequence

	sequence s_data_ack_end;
		link_on && !ev.start && !ev.stop && state_r == sip_pkg::ST_RXACK
			&& kind_r == sip_pkg::K_DATA && ev.scl_fall;
	endsequence

	a_addr_match_ack: assert property (s_addr_byte_done ##0 addr_hit |=> sda_oe_r && state_r == sip_pkg::ST_RXACK)
		else $error("own address not acknowledged");

	a_addr_lsb_pin: assert property (s_addr_byte_done ##0 (shift_r[7:1] == {sip_pkg::ADDR_HI, !ev.ad0_lvl}) |=> !sda_oe_r)
		else $error("address low bit did not follow the select pin");

	a_mismatch_ignore: assert property (s_addr_byte_done ##0 !addr_hit |=> state_r == sip_pkg::ST_IGN [*2] ##0 !sda_oe_r)
		else $error("foreign address not ignored");

	a_idle_hands_off: assert property (state_r == sip_pkg::ST_IDLE |-> !scl_oe_r && !wr_en_r)
		else $error("idle target drives the link");

	a_start_busy: assert property (link_on && ev.start |=> busy_r && state_r == sip_pkg::ST_RX && cnt_r == 4'h0)
		else $error("start not taken");

	a_stop_free: assert property (link_on && ev.stop && !ev.start |=> !busy_r && !sda_oe_r && !scl_oe_r)
		else $error("stop did not free the bus");

	a_busy_hold: assert property (busy_r && link_on && !ev.stop |=> busy_r)
		else $error("bus dropped busy without stop");

	a_ack_hold_high: assert property (state_r == sip_pkg::ST_RXACK && ev.scl_lvl && !ev.scl_fall && !ev.stop
		&& !ev.start && link_on |=> sda_oe_r)
		else $error("acknowledge released during clock high");

	a_stretch_release: assert property (rd_take && link_on && !ev.start && !ev.stop
		|=> scl_oe_r && state_r == sip_pkg::ST_TX ##1 !scl_oe_r)
		else $error("clock stretch not released on data");

	a_tx_stable_high: assert property (state_r == sip_pkg::ST_TX && ev.scl_lvl && !ev.scl_fall |=> $stable(sda_oe_r))
		else $error("data changed while clock high");

	a_write_store: assert property (link_on && !ev.start && !ev.stop && state_r == sip_pkg::ST_RX
		&& kind_r == sip_pkg::K_DATA && byte_done |=> wr_en_r && wr_data_r == $past(shift_r))
		else $error("data byte not stored");

	a_write_incr: assert property (s_data_ack_end |=> idx_r == $past(idx_r) + 8'h01)
		else $error("write index did not advance");

	a_nack_release: assert property (link_on && !ev.start && !ev.stop && state_r == sip_pkg::ST_TXACK && ev.scl_rise
		&& ev.sda_lvl |=> state_r == sip_pkg::ST_IGN ##1 !sda_oe_r)
		else $error("device kept driving after not-acknowledge");

	a_burst_next: assert property (link_on && !ev.start && !ev.stop && state_r == sip_pkg::ST_TXNXT && ev.scl_fall
		|=> rd_req_r && scl_oe_r && idx_r == $past(idx_r) + 8'h01)
		else $error("burst read did not advance");

	a_spi_quiet: assert property (!link_on |=> !sda_oe_r && !scl_oe_r && !busy_r)
		else $error("two-wire port active while disabled");

endmodule // sip_target_port

// File: tb/sip_host_model.sv
// bus controller model for the two-wire target port
`timescale 1ns/100ps
module sip_host_model (
	input  wire logic  mclk_in,     // bench clock, paces the link
	input  wire logic  scl_in,      // resolved clock wire
	input  wire logic  sda_in,      // resolved data wire
	output logic       scl_oe_out,  // high pulls clock low
	output logic       sda_oe_out,  // high pulls data low
	output logic       rd_stb_out,  // one-cycle pulse per byte read
	output logic [7:0] rd_byte_out, // byte read from the target
	output logic       hang_out     // a stretch outlasted its bound
);
	// lines released at time zero; the pull-ups make them high
	initial
	begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
		rd_stb_out = 1'b0;
		rd_byte_out = 8'h00;
		hang_out = 1'b0;
	end

	// quarter of the 160 ns link period, far above the 400 kHz ceiling
	task automatic qtr();
		repeat (8) @(posedge mclk_in);
		#1;
	endtask

	// one clock pulse: data moves mid-low, sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		int n;
		qtr();
		sda_oe_out = !b;
		qtr();
		scl_oe_out = 1'b0;
		n = 0;
		// a busy target holds the clock low; wait, but bounded
		while (scl_in !== 1'b1 && n < 4000)
		begin
			@(posedge mclk_in);
			n++;
		end
		#1;
		if (n >= 4000)
			hang_out = 1'b1;
		qtr();
		r = sda_in;
		qtr();
		scl_oe_out = 1'b1;
	endtask

	// data falls while clock is high; also serves as repeated start
	task automatic bus_start();
		qtr();
		sda_oe_out = 1'b0;
		qtr();
		scl_oe_out = 1'b0;
		qtr();
		sda_oe_out = 1'b1;
		qtr();
		scl_oe_out = 1'b1;
	endtask

	// data rises while clock is high
	task automatic bus_stop();
		qtr();
		sda_oe_out = 1'b1;
		qtr();
		scl_oe_out = 1'b0;
		qtr();
		sda_oe_out = 1'b0;
		qtr();
	endtask

	// eight bits msb first, then data released for the target's answer
	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, ack);
	endtask

	// host acknowledges every byte but the last
	task automatic read_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
		rd_byte_out = d;
		rd_stb_out = 1'b1;
		@(posedge mclk_in);
		#1;
		rd_stb_out = 1'b0;
	endtask
endmodule // sip_host_model

// File: tb/tb_top.sv
// self-checking bench for the two-wire target port
`timescale 1ns/100ps
module tb_top;
	logic       mclk_in, arst_n_in, scl_w, sda_w, scl_out, scl_oe_out, sda_out, sda_oe_out;
	logic       addr_sel, asp_out, asp_oe_out, dis, sdo, sdo_oe, spi_sclk_out, spi_sdi_out;
	logic       busy_out, wr_en_out, rd_req_out, rd_ready_in, h_scl_oe, h_sda_oe, h_stb, h_hang;
	logic [7:0] register_index_out, wr_data_out, rd_data_in, h_byte, idx;
	logic [7:0] mem [256];
	logic [7:0] exp_mem [256];
	logic [15:0] exp_wr[$];
	logic [7:0]  exp_rd[$];
	int         n_errors, comparisons, cycles;
	int         seed = 32'h52458AF9;

	// open-drain wires with pull-ups: low if anyone pulls
	assign scl_w = !(h_scl_oe | scl_oe_out);
	assign sda_w = !(h_sda_oe | sda_oe_out);

	sip_target_port i_sip_target_port (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .scl_in(scl_w),
		.scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe_out(sda_oe_out), .addr_select_pin_in(addr_sel), .addr_select_pin_out(asp_out),
		.addr_select_pin_oe_out(asp_oe_out), .twowire_port_disable_in(dis), .spi_sdo_in(sdo),
		.spi_sdo_oe_in(sdo_oe), .spi_sclk_out(spi_sclk_out), .spi_sdi_out(spi_sdi_out),
		.busy_out(busy_out), .register_index_out(register_index_out), .wr_en_out(wr_en_out),
		.wr_data_out(wr_data_out), .rd_req_out(rd_req_out), .rd_ready_in(rd_ready_in),
		.rd_data_in(rd_data_in));

	sip_host_model i_sip_host_model (.mclk_in(mclk_in), .scl_in(scl_w), .sda_in(sda_w),
		.scl_oe_out(h_scl_oe), .sda_oe_out(h_sda_oe), .rd_stb_out(h_stb), .rd_byte_out(h_byte),
		.hang_out(h_hang));

	always #2.5 mclk_in = ~mclk_in;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (n_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// register side and result watcher
	// ----------------------------------------
	// random fetch latency makes the port stretch the clock
	always
	begin
		@(posedge mclk_in);
		#1;
		if (rd_req_out === 1'b1)
		begin
			repeat (1 + {$random(seed)} % 24) @(posedge mclk_in);
			#1;
			rd_data_in = mem[register_index_out];
			rd_ready_in = 1'b1;
			@(posedge mclk_in);
			#1;
			rd_ready_in = 1'b0;
			rd_data_in = 8'($random(seed)); // stale data never looks valid
		end
	end

	// each store or read byte takes the oldest note; sampled on the falling
	// edge so a one-cycle strobe set just after a rising edge is seen once
	always
	begin
		@(negedge mclk_in);
		if (wr_en_out === 1'b1)
		begin
			mem[register_index_out] = wr_data_out;
			if (exp_wr.size() == 0)
				check(1'b1, 1'b0, "store not expected");
			else
				check({register_index_out, wr_data_out}, exp_wr.pop_front(), "store");
		end
		if (h_stb === 1'b1 && exp_rd.size() == 0)
			check(1'b1, 1'b0, "read byte not expected");
		else if (h_stb === 1'b1)
			check(h_byte, exp_rd.pop_front(), "read byte");
	end

	// limit sized for about 100 bytes with stretches
	always @(posedge mclk_in)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_errors++;
			$display("unexpected at %0t: run limit reached", $time);
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// transfers
	// ----------------------------------------
	task automatic wr_burst(input logic [6:0] ta, input logic [7:0] ix, input int n, input logic ok);
		logic       ack;
		logic [7:0] d;
		i_sip_host_model.bus_start();
		i_sip_host_model.write_byte({ta, 1'b0}, ack);
		check(ack, !ok, "address answer");
		if (dis === 1'b0)
			check(busy_out, 1'b1, "busy in transfer");
		i_sip_host_model.write_byte(ix, ack);
		check(ack, !ok, "index answer");
		for (int k = 0; k < n; k++)
		begin
			d = 8'($random(seed));
			if (ok)
			begin
				exp_wr.push_back({ix + k[7:0], d});
				exp_mem[ix + k[7:0]] = d;
			end
			i_sip_host_model.write_byte(d, ack);
			check(ack, !ok, "data answer");
		end
		i_sip_host_model.bus_stop();
		check(busy_out, 1'b0, "busy after stop");
	endtask

	task automatic rd_burst(input logic [6:0] ta, input logic [7:0] ix, input int n);
		logic       ack;
		logic [7:0] d;
		i_sip_host_model.bus_start();
		i_sip_host_model.write_byte({ta, 1'b0}, ack);
		check(ack, 1'b0, "address answer");
		i_sip_host_model.write_byte(ix, ack);
		check(ack, 1'b0, "index answer");
		i_sip_host_model.bus_start();
		check(busy_out, 1'b1, "busy over repeated start");
		i_sip_host_model.write_byte({ta, 1'b1}, ack);
		check(ack, 1'b0, "read address answer");
		for (int k = 0; k < n; k++)
		begin
			exp_rd.push_back(exp_mem[ix + k[7:0]]);
			i_sip_host_model.read_byte(k == n - 1, d);
		end
		i_sip_host_model.bus_stop();
		check(sda_oe_out, 1'b0, "data released after read");
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		mclk_in = 1'b0;
		arst_n_in = 1'b0;
		addr_sel = 1'b0;
		dis = 1'b0;
		sdo = 1'b0;
		sdo_oe = 1'b0;
		rd_ready_in = 1'b0;
		rd_data_in = 8'h00;
		for (int i = 0; i < 256; i++)
		begin
			mem[i] = i[7:0] ^ 8'hA5;
			exp_mem[i] = i[7:0] ^ 8'hA5;
		end
		repeat (6) @(posedge mclk_in);
		#1;
		arst_n_in = 1'b1;
		check({busy_out, scl_oe_out, sda_oe_out, register_index_out}, 16'h0000, "reset state");
		// both address-select levels; index FE shows the wrap to 00
		for (int a = 0; a < 2; a++)
		begin
			addr_sel = a[0];
			idx = a[0] ? 8'hFE : 8'($random(seed));
			repeat (4) @(posedge mclk_in);
			#1;
			wr_burst({sip_pkg::ADDR_HI, a[0]}, idx, 3, 1'b1);
			wr_burst({sip_pkg::ADDR_HI, !a[0]}, idx, 1, 1'b0);
			rd_burst({sip_pkg::ADDR_HI, a[0]}, idx, 3);
			check({scl_out, sda_out}, 2'b00, "pins only pull low");
		end
		// the host takes the pins for spi use
		dis = 1'b1;
		sdo_oe = 1'b1;
		sdo = 1'($random(seed));
		repeat (4) @(posedge mclk_in);
		#1;
		check({asp_oe_out, asp_out}, {1'b1, sdo}, "select pin as spi output");
		check({spi_sclk_out, spi_sdi_out}, {scl_w, sda_w}, "spi inputs");
		wr_burst({sip_pkg::ADDR_HI, 1'b1}, 8'h10, 1, 1'b0);
		// spi enable left high: the select pin must still return to input
		dis = 1'b0;
		// second reset in mid-run, then a plain write
		arst_n_in = 1'b0;
		repeat (2) @(posedge mclk_in);
		#1;
		arst_n_in = 1'b1;
		repeat (4) @(posedge mclk_in);
		#1;
		check({asp_oe_out, busy_out, register_index_out}, 16'h0000, "state after second reset");
		sdo_oe = 1'b0;
		wr_burst({sip_pkg::ADDR_HI, 1'b1}, 8'h40, 2, 1'b1);
		repeat (20) @(posedge mclk_in);
		check(exp_wr.size() + exp_rd.size(), 16'h0000, "results outstanding");
		check(h_hang, 1'b0, "stretch released");
		tally_and_finish();
	end
endmodule // tb_top
